// [sbd_pkg.sv]
// Purpose: shared constants and types for the s bus d-channel and sync block
// Assumes: one core clock; bit strobes come from logic on that clock
// Notes: frame positions count from 0 at the framing bit
package sbd_pkg;
  typedef enum logic [1:0] {SBD_TE, SBD_LT_T, SBD_NT, SBD_LT_S} sbd_mode_t;
  typedef enum logic [1:0] {SY_HUNT, SY_ACQ, SY_LOCK, SY_MISS} sbd_sync_t;
  // ****************************************
  // frame layout
  // ****************************************
  localparam int unsigned FRAME_BITS = 48;
  localparam logic [5:0] POS_F = 6'h00;
  localparam logic [5:0] POS_E = 6'h0a;
  localparam logic [5:0] POS_D = 6'h0b;
  localparam logic [5:0] POS_FA = 6'h0d;
  localparam logic [5:0] POS_CV16 = 6'h10;
  localparam logic [6:0] SG_POS_FOUR = 7'h14;
  localparam logic [6:0] SG_POS_TWELVE = 7'h5a;
  // ****************************************
  // counts, codes and reset values
  // ****************************************
  localparam logic [2:0] LOCK_GOOD_FRAMES = 3'h3;
  localparam logic [2:0] UP_DELAY_FRAMES = 3'h2;
  localparam logic [2:0] IFMODE_ACCESS_A = 3'h1;
  localparam logic [2:0] IFMODE_ACCESS_B = 3'h3;
  localparam logic [3:0] PRIO_EIGHT_ONES = 4'h8;
  localparam logic [3:0] PRIO_TEN_ONES = 4'ha;
  localparam logic RST_FA = 1'b1;
  localparam logic RST_LINE_D = 1'b1;
  localparam logic RST_ECHO = 1'b1;
  localparam logic RST_SG = 1'b0;

  function automatic logic sbd_is_net(input sbd_mode_t m);
    sbd_is_net = (m == SBD_NT) || (m == SBD_LT_S);
  endfunction
endpackage

// [sbd_dca_if.sv]
// Purpose: carries d-channel access signals between top and access unit
// Assumes: both ends on the core clock
// Notes: none
interface sbd_dca_if;
  logic en;
  logic prio_ten;
  logic echo_stb;
  logic echo_bit;
  logic sent_d;
  logic stop;
  logic coll;
  modport ctl(output en, prio_ten, echo_stb, echo_bit, sent_d,
              input stop, coll);
  modport unit(input en, prio_ten, echo_stb, echo_bit, sent_d,
               output stop, coll);
endinterface

// [sbd_bitpos.sv]
// Purpose: receive bit position counter within an s frame
// Assumes: i_realign only matters together with i_stb
// Notes: o_pos is the position of the bit now strobed
module sbd_bitpos #(
  parameter int unsigned FRAME_LEN = sbd_pkg::FRAME_BITS
) (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire logic i_stb,
  input wire logic i_realign,
  output logic [5:0] o_pos,
  output logic o_frame_end
);
  import sbd_pkg::*;
  logic [5:0] cnt_r;
  logic [5:0] cnt_nxt;

  always_comb begin
    o_pos = i_realign ? POS_F : cnt_r;
    o_frame_end = i_stb && (o_pos == 6'(FRAME_LEN - 1));
    cnt_nxt = cnt_r;
    if (i_stb) begin
      cnt_nxt = o_frame_end ? POS_F : 6'(o_pos + 6'h01);
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cnt_r <= POS_F;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
endmodule

// [sbd_dchan_access.sv]
// Purpose: d-channel collision detection and priority wait
// Assumes: echo strobe once per frame at the echo bit
// Notes: go is released one echo bit ahead of the free channel
module sbd_dchan_access (
  input wire logic i_core_clk,
  input wire logic i_srst,
  sbd_dca_if.unit dca
);
  import sbd_pkg::*;
  logic stop_r;
  logic stop_nxt;
  logic coll_r;
  logic coll_nxt;
  logic [3:0] ones_r;
  logic [3:0] ones_nxt;
  logic [3:0] need;

  always_comb begin
    need = dca.prio_ten ? PRIO_TEN_ONES : PRIO_EIGHT_ONES;
    stop_nxt = stop_r;
    ones_nxt = ones_r;
    coll_nxt = 1'b0;
    if (!dca.en) begin
      stop_nxt = 1'b0;
      ones_nxt = 4'h0;
    end else if (dca.echo_stb) begin
      if (!stop_r && (dca.echo_bit != dca.sent_d)) begin
        stop_nxt = 1'b1;
        coll_nxt = 1'b1;
        ones_nxt = 4'h0;
      end else if (stop_r) begin
        if (!dca.echo_bit) begin
          ones_nxt = 4'h0;
        end else if (ones_r == 4'(need - 4'h2)) begin
          stop_nxt = 1'b0;
          ones_nxt = 4'h0;
        end else begin
          ones_nxt = 4'(ones_r + 4'h1);
        end
      end
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      stop_r <= 1'b0;
      coll_r <= 1'b0;
      ones_r <= 4'h0;
    end else begin
      stop_r <= stop_nxt;
      coll_r <= coll_nxt;
      ones_r <= ones_nxt;
    end
  end

  assign dca.stop = stop_r;
  assign dca.coll = coll_r;

  property p_coll_stop;
    @(posedge i_core_clk) disable iff (i_srst)
    (dca.en && dca.echo_stb && !stop_r && dca.echo_bit != dca.sent_d)
      |=> (stop_r && coll_r);
  endproperty
  a_coll_stop: assert property (p_coll_stop)
    else $error("collision did not stop d channel");

  property p_go_early;
    @(posedge i_core_clk) disable iff (i_srst)
    (dca.en && dca.echo_stb && stop_r && dca.echo_bit &&
     ones_r == 4'(need - 4'h2)) |=> !stop_r;
  endproperty
  a_go_early: assert property (p_go_early)
    else $error("go not released one bit ahead");
endmodule

// [sbd_s_access.sv]
// Purpose: frame alignment, fa mirroring and d-channel access for s bus
// Assumes: rx and terminal bus strobes come from logic on the core clock
// Notes: outputs are registered; strobes are one-cycle pulses
module sbd_s_access (
  input wire logic i_core_clk,
  input wire logic i_srst,
  input wire sbd_pkg::sbd_mode_t i_layer_mode,
  input wire logic [2:0] i_dchan_iface_mode_sel,
  input wire logic i_trunk_access_en,
  input wire logic i_prio_ten,
  input wire logic i_multiframe_disable,
  input wire logic i_mf_sync,
  input wire logic i_q_frame,
  input wire logic [1:0] i_q_slot,
  input wire logic [3:0] i_q_bit_tx_values,
  input wire logic i_rx_stb,
  input wire logic i_rx_bit,
  input wire logic i_rx_cv,
  input wire logic i_tb_stb,
  input wire logic [6:0] i_tb_pos,
  input wire logic i_tb_twelve_byte,
  input wire logic i_tb_d_bit,
  output logic o_frame_locked,
  output logic o_upstream_en,
  output logic o_line_tx_fa,
  output logic o_line_tx_d,
  output logic o_line_tx_echo,
  output logic o_tb_sg,
  output logic o_tb_sg_stb,
  output logic o_collision
);
  import sbd_pkg::*;

  // ****************************************
  // mode decode
  // ****************************************
  logic net;
  logic term;
  logic access_en;
  logic ifmode_ok;

  always_comb begin
    net = sbd_is_net(i_layer_mode);
    term = !net;
    ifmode_ok = (i_dchan_iface_mode_sel == IFMODE_ACCESS_A) ||
                (i_dchan_iface_mode_sel == IFMODE_ACCESS_B);
    access_en = term && ifmode_ok &&
                ((i_layer_mode == SBD_TE) || i_trunk_access_en);
  end

  // ****************************************
  // bit position
  // ****************************************
  sbd_sync_t st_r;
  sbd_sync_t st_nxt;
  logic realign;
  logic [5:0] pos;
  logic fe;

  assign realign = term && (st_r == SY_HUNT) && i_rx_cv;

  sbd_bitpos #(.FRAME_LEN(FRAME_BITS)) u_bitpos (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .i_stb(i_rx_stb),
    .i_realign(realign),
    .o_pos(pos),
    .o_frame_end(fe)
  );

  // ****************************************
  // frame check
  // ****************************************
  logic cvf_r;
  logic cvf_nxt;
  logic ones_r;
  logic ones_nxt;
  logic v16_r;
  logic v16_nxt;
  logic good;

  always_comb begin
    cvf_nxt = cvf_r;
    ones_nxt = ones_r;
    v16_nxt = v16_r;
    if (i_rx_stb) begin
      if (pos == POS_F) begin
        cvf_nxt = i_rx_cv;
        ones_nxt = 1'b1;
        v16_nxt = 1'b0;
      end else if (pos < POS_CV16) begin
        ones_nxt = ones_r && i_rx_bit && !i_rx_cv;
      end else if (pos == POS_CV16) begin
        v16_nxt = ones_r && i_rx_cv;
      end
    end
    good = cvf_r || v16_r;
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cvf_r <= 1'b0;
      ones_r <= 1'b0;
      v16_r <= 1'b0;
    end else begin
      cvf_r <= cvf_nxt;
      ones_r <= ones_nxt;
      v16_r <= v16_nxt;
    end
  end

  // ****************************************
  // alignment state machine
  // ****************************************
  logic [2:0] gcnt_r;
  logic [2:0] gcnt_nxt;
  logic [2:0] upcnt_r;
  logic [2:0] upcnt_nxt;
  logic up_nxt;
  logic lock_nxt;

  always_comb begin
    st_nxt = st_r;
    gcnt_nxt = gcnt_r;
    upcnt_nxt = upcnt_r;
    up_nxt = o_upstream_en;
    if (net) begin
      st_nxt = SY_HUNT;
      up_nxt = 1'b0;
    end else if (fe) begin
      case (st_r)
        SY_HUNT: begin
          if (good) begin
            st_nxt = SY_ACQ;
            gcnt_nxt = 3'h1;
          end
        end
        SY_ACQ: begin
          if (!good) begin
            st_nxt = SY_HUNT;
          end else if (gcnt_r == 3'(LOCK_GOOD_FRAMES - 3'h1)) begin
            st_nxt = SY_LOCK;
            upcnt_nxt = 3'h0;
          end else begin
            gcnt_nxt = 3'(gcnt_r + 3'h1);
          end
        end
        SY_LOCK: begin
          if (!good) begin
            st_nxt = SY_MISS;
          end else if (!o_upstream_en) begin
            if (upcnt_r == 3'(UP_DELAY_FRAMES - 3'h1)) begin
              up_nxt = 1'b1;
            end else begin
              upcnt_nxt = 3'(upcnt_r + 3'h1);
            end
          end
        end
        SY_MISS: begin
          if (good) begin
            st_nxt = SY_LOCK;
          end else begin
            st_nxt = SY_HUNT;
            up_nxt = 1'b0;
          end
        end
        default: st_nxt = SY_HUNT;
      endcase
    end
    lock_nxt = (st_nxt == SY_LOCK) || (st_nxt == SY_MISS);
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      st_r <= SY_HUNT;
      gcnt_r <= 3'h0;
      upcnt_r <= 3'h0;
      o_upstream_en <= 1'b0;
      o_frame_locked <= 1'b0;
    end else begin
      st_r <= st_nxt;
      gcnt_r <= gcnt_nxt;
      upcnt_r <= upcnt_nxt;
      o_upstream_en <= up_nxt;
      o_frame_locked <= lock_nxt;
    end
  end

  // ****************************************
  // fa bit, line d and echo
  // ****************************************
  sbd_dca_if dca ();
  logic fa_rx_r;
  logic fa_rx_nxt;
  logic fa_nxt;
  logic d_nxt;
  logic echo_nxt;

  always_comb begin
    fa_rx_nxt = fa_rx_r;
    if (term && i_rx_stb && (pos == POS_FA)) begin
      fa_rx_nxt = i_rx_bit;
    end
    if (i_mf_sync && !i_multiframe_disable) begin
      fa_nxt = i_q_frame && i_q_bit_tx_values[i_q_slot];
    end else begin
      fa_nxt = fa_rx_r;
    end
    if (access_en && dca.stop) begin
      d_nxt = 1'b1;
    end else begin
      d_nxt = i_tb_d_bit;
    end
    echo_nxt = o_line_tx_echo;
    if (!net) begin
      echo_nxt = RST_ECHO;
    end else if (i_rx_stb && (pos == POS_D)) begin
      echo_nxt = i_rx_bit;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      fa_rx_r <= RST_FA;
      o_line_tx_fa <= RST_FA;
      o_line_tx_d <= RST_LINE_D;
      o_line_tx_echo <= RST_ECHO;
    end else begin
      fa_rx_r <= fa_rx_nxt;
      o_line_tx_fa <= fa_nxt;
      o_line_tx_d <= d_nxt;
      o_line_tx_echo <= echo_nxt;
    end
  end

  // ****************************************
  // collision unit and stop/go
  // ****************************************
  logic [6:0] sg_pos;
  logic sg_hit;
  logic sg_nxt;

  assign dca.en = access_en;
  assign dca.prio_ten = i_prio_ten;
  assign dca.echo_stb = i_rx_stb && (pos == POS_E) && o_frame_locked;
  assign dca.echo_bit = i_rx_bit;
  assign dca.sent_d = o_line_tx_d;

  sbd_dchan_access u_access (
    .i_core_clk(i_core_clk),
    .i_srst(i_srst),
    .dca(dca.unit)
  );

  always_comb begin
    sg_pos = i_tb_twelve_byte ? SG_POS_TWELVE : SG_POS_FOUR;
    sg_hit = i_tb_stb && (i_tb_pos == sg_pos);
    sg_nxt = o_tb_sg;
    if (sg_hit) begin
      sg_nxt = access_en && dca.stop;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      o_tb_sg <= RST_SG;
      o_tb_sg_stb <= 1'b0;
      o_collision <= 1'b0;
    end else begin
      o_tb_sg <= sg_nxt;
      o_tb_sg_stb <= sg_hit;
      o_collision <= dca.coll;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_one_bad_keep;
    @(posedge i_core_clk) disable iff (i_srst)
    (term && fe && !good && st_r == SY_LOCK) |=> o_frame_locked;
  endproperty
  a_one_bad_keep: assert property (p_one_bad_keep)
    else $error("lost alignment on one bad frame");

  property p_two_bad_lose;
    @(posedge i_core_clk) disable iff (i_srst)
    (term && fe && !good && st_r == SY_MISS)
      |=> (!o_frame_locked && !o_upstream_en);
  endproperty
  a_two_bad_lose: assert property (p_two_bad_lose)
    else $error("alignment kept after two bad frames");

  property p_v16_valid;
    @(posedge i_core_clk) disable iff (i_srst)
    (term && fe && v16_r && st_r == SY_LOCK) |=> (st_r == SY_LOCK);
  endproperty
  a_v16_valid: assert property (p_v16_valid)
    else $error("bit 16 violation frame not accepted");

  property p_up_after_lock;
    @(posedge i_core_clk) disable iff (i_srst)
    $rose(o_upstream_en) |-> (o_frame_locked && $past(fe));
  endproperty
  a_up_after_lock: assert property (p_up_after_lock)
    else $error("upstream enabled without alignment");

  property p_fa_mirror;
    @(posedge i_core_clk) disable iff (i_srst)
    (term && i_rx_stb && pos == POS_FA && !i_mf_sync)
      ##1 !i_mf_sync |=> (o_line_tx_fa == $past(i_rx_bit, 2));
  endproperty
  a_fa_mirror: assert property (p_fa_mirror)
    else $error("fa bit not mirrored");

  property p_transparent;
    @(posedge i_core_clk) disable iff (i_srst)
    net |=> (o_line_tx_d == $past(i_tb_d_bit));
  endproperty
  a_transparent: assert property (p_transparent)
    else $error("network d bit not transparent");

  property p_echo_gen;
    @(posedge i_core_clk) disable iff (i_srst)
    (net && i_rx_stb && pos == POS_D) |=> (o_line_tx_echo == $past(i_rx_bit));
  endproperty
  a_echo_gen: assert property (p_echo_gen)
    else $error("echo bit not generated");

  property p_sg_slot;
    @(posedge i_core_clk) disable iff (i_srst)
    sg_hit |=> (o_tb_sg_stb && o_tb_sg == $past(access_en && dca.stop));
  endproperty
  a_sg_slot: assert property (p_sg_slot)
    else $error("stop/go slot value wrong");
endmodule

// [sbd_peer.sv]
// Purpose: s bus peer and layer-2 controller model facing the access block
// Assumes: one received bit strobe every second core clock cycle
// Notes: between strobes the rx lines carry the inverse of the last value
module sbd_peer (
  input wire logic i_core_clk,
  input wire logic i_sg,
  input wire logic i_sg_stb,
  input wire logic i_want_d,
  output logic o_rx_stb,
  output logic o_rx_bit,
  output logic o_rx_cv,
  output logic o_tb_d_bit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic stop_seen = 1'b0;

  initial begin
    o_rx_stb = 1'b0;
    o_rx_bit = 1'b1;
    o_rx_cv = 1'b0;
    o_tb_d_bit = 1'b1;
  end

  // ****************************************
  // layer 2: hold d output high on stop
  // ****************************************
  always @(posedge i_core_clk) begin
    if (i_sg_stb) stop_seen <= i_sg;
  end
  always @(negedge i_core_clk) begin
    o_tb_d_bit <= stop_seen | i_want_d;
  end

  // ****************************************
  // line frames: 0 good, 1 unframed, 2 ones up to a violation at bit 16
  // ****************************************
  task automatic send_frame(input int kind, input logic fa, e, d);
    for (int p = 0; p < 48; p++) begin
      @(negedge i_core_clk);
      o_rx_stb = 1'b1;
      o_rx_cv = (kind == 0 && p == 0) || (kind == 2 && p == 16);
      o_rx_bit = o_rx_cv ? 1'b0 : (kind != 0) ? 1'b1 :
                 (p == 10) ? e : (p == 11) ? d : (p == 13) ? fa : 1'b1;
      @(negedge i_core_clk);
      o_rx_stb = 1'b0;
      o_rx_bit = ~o_rx_bit;
      o_rx_cv = ~o_rx_cv;
    end
  endtask
endmodule

// [testbench.sv]
// Purpose: self-checking bench for the s bus sync and d-channel block
// Assumes: inputs change at the falling edge of the core clock
// Notes: the peer model supplies line frames and the layer-2 d bit
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import sbd_pkg::*;
  logic core_clk = 1'b0, srst = 1'b1, trunk_en = 1'b0, prio_ten = 1'b0;
  sbd_mode_t mode = SBD_TE;
  logic [2:0] if_mode = 3'h0;
  logic mf_dis = 1'b0, mf_sync = 1'b0, q_frame = 1'b0;
  logic [1:0] q_slot = 2'h0;
  logic [3:0] q_vals = 4'hf;
  logic tb_stb = 1'b0, tb_twelve = 1'b0, want_d = 1'b1;
  logic [6:0] tb_pos = 7'h00;
  logic rx_stb, rx_bit, rx_cv, tb_d;
  logic locked, up_en, tx_fa, tx_d, tx_echo, sg, sg_stb, coll;
  int n_fail = 0, n_tests = 0, n_coll = 0;

  sbd_peer u_peer (
    .i_core_clk(core_clk),
    .i_sg(sg),
    .i_sg_stb(sg_stb),
    .i_want_d(want_d),
    .o_rx_stb(rx_stb),
    .o_rx_bit(rx_bit),
    .o_rx_cv(rx_cv),
    .o_tb_d_bit(tb_d)
  );

  sbd_s_access u_dut (
    .i_core_clk(core_clk),
    .i_srst(srst),
    .i_layer_mode(mode),
    .i_dchan_iface_mode_sel(if_mode),
    .i_trunk_access_en(trunk_en),
    .i_prio_ten(prio_ten),
    .i_multiframe_disable(mf_dis),
    .i_mf_sync(mf_sync),
    .i_q_frame(q_frame),
    .i_q_slot(q_slot),
    .i_q_bit_tx_values(q_vals),
    .i_rx_stb(rx_stb),
    .i_rx_bit(rx_bit),
    .i_rx_cv(rx_cv),
    .i_tb_stb(tb_stb),
    .i_tb_pos(tb_pos),
    .i_tb_twelve_byte(tb_twelve),
    .i_tb_d_bit(tb_d),
    .o_frame_locked(locked),
    .o_upstream_en(up_en),
    .o_line_tx_fa(tx_fa),
    .o_line_tx_d(tx_d),
    .o_line_tx_echo(tx_echo),
    .o_tb_sg(sg),
    .o_tb_sg_stb(sg_stb),
    .o_collision(coll)
  );

  initial begin
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (coll === 1'b1) n_coll <= n_coll + 1;
  end

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic check(input logic [7:0] got, exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    if (n_fail == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic frame(input int kind, input logic fa, e, d);
    u_peer.send_frame(kind, fa, e, d);
    repeat (2) @(negedge core_clk);
  endtask

  // one stop/go slot strobe, then the flag and its one-cycle pulse
  task automatic slot(input logic [6:0] pos, input logic exp);
    @(negedge core_clk);
    tb_stb = 1'b1;
    tb_pos = pos;
    @(negedge core_clk);
    tb_stb = 1'b0;
    tb_pos = ~pos;
    check({sg, sg_stb}, {exp, 1'b1});
    @(negedge core_clk);
    check(sg_stb, 1'b0);
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_lock();
    for (int i = 0; i < 6; i++) begin
      frame(0, i[0], 1'b1, 1'b1);
      if (i == 1) check(locked, 1'b0);
      if (i == 3) check({locked, up_en}, 2'h2);
      check(tx_fa, i[0]);
    end
    check({locked, up_en}, 2'h3);
    mf_sync = 1'b1;
    q_frame = 1'b0;
    q_slot = 2'h2;
    repeat (2) @(negedge core_clk);
    check(tx_fa, 1'b0);
    q_frame = 1'b1;
    repeat (2) @(negedge core_clk);
    check(tx_fa, 1'b1);
    q_frame = 1'b0;
    mf_dis = 1'b1;
    repeat (2) @(negedge core_clk);
    check(tx_fa, 1'b1);
    mf_dis = 1'b0;
    mf_sync = 1'b0;
  endtask

  task automatic t_miss();
    frame(1, 1'b1, 1'b1, 1'b1);
    check(locked, 1'b1);
    frame(0, 1'b0, 1'b1, 1'b1);
    frame(2, 1'b1, 1'b1, 1'b1);
    check(tx_fa, 1'b1);
    frame(2, 1'b1, 1'b1, 1'b1);
    check({locked, up_en}, 2'h3);
    frame(1, 1'b1, 1'b1, 1'b1);
    check(locked, 1'b1);
    frame(1, 1'b1, 1'b1, 1'b1);
    check({locked, up_en}, 2'h0);
    for (int i = 0; i < 5; i++) frame(0, 1'b0, 1'b1, 1'b1);
    check({locked, up_en}, 2'h3);
  endtask

  // collision, stop, then the priority wait with a zero echo midway
  task automatic t_coll();
    int c0;
    for (int pr = 0; pr < 2; pr++) begin
      prio_ten = pr[0];
      if_mode = pr[0] ? 3'h3 : 3'h1;
      want_d = 1'b0;
      c0 = n_coll;
      frame(0, 1'b0, 1'b1, 1'b1);
      check(n_coll, c0 + 1);
      check(tx_d, 1'b1);
      slot(7'h14, 1'b1);
      for (int i = 0; i < 11 + 2 * pr; i++) begin
        frame(0, 1'b0, i != 3, 1'b1);
        slot(7'h14, i < 10 + 2 * pr);
      end
      check(n_coll, c0 + 1);
    end
    want_d = 1'b1;
  endtask

  task automatic t_trunk();
    int c0;
    mode = SBD_LT_T;
    if_mode = 3'h1;
    repeat (3) frame(0, 1'b0, 1'b1, 1'b1);
    c0 = n_coll;
    for (int t = 0; t < 2; t++) begin
      trunk_en = t[0];
      frame(0, 1'b0, 1'b0, 1'b1);
      check(n_coll, c0 + t);
    end
    slot(7'h14, 1'b1);
  endtask

  task automatic t_net();
    tb_twelve = 1'b1;
    for (int k = 0; k < 2; k++) begin
      mode = k[0] ? SBD_LT_S : SBD_NT;
      slot(7'h5a, 1'b0);
      want_d = k[0];
      repeat (3) @(negedge core_clk);
      check(tx_d, k[0]);
      frame(0, 1'b1, 1'b1, k[0]);
      check({locked, tx_echo}, {1'b0, k[0]});
    end
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (6) @(negedge core_clk);
    check({locked, up_en, tx_fa, tx_d, tx_echo, sg, sg_stb, coll},
          8'h38);
    srst = 1'b0;
    t_lock();
    t_miss();
    t_coll();
    t_trunk();
    t_net();
    give_verdict();
  end

  // cuts a hang short
  initial begin
    #2000000;
    n_fail++;
    give_verdict();
  end
endmodule
